/* File: verilog/tpwm_top.v */
// two-channel pwm timer with axi4-lite register access
`timescale 1ns/1ns
`include "tpwm_defines.vh"
module tpwm_top (
  input wire MCLK,
  input wire RST,
  input wire [7:0] AWADDR,
  input wire AWVALID,
  output wire AWREADY,
  input wire [31:0] WDATA,
  input wire [3:0] WSTRB,
  input wire WVALID,
  output wire WREADY,
  output wire [1:0] BRESP,
  output wire BVALID,
  input wire BREADY,
  input wire [7:0] ARADDR,
  input wire ARVALID,
  output wire ARREADY,
  output wire [31:0] RDATA,
  output wire [1:0] RRESP,
  output wire RVALID,
  input wire RREADY,
  input wire WAIT_MODE,
  input wire STOP_MODE,
  input wire BREAK_ACTIVE,
  input wire BREAK_CLEAR_EN,
  input wire EXT_CLK,
  input wire CH0_IN,
  input wire CH1_IN,
  output wire CH0_OUT,
  output wire CH0_OE,
  output wire CH1_OUT,
  output wire CH1_OE,
  output wire EXT_CLK_FORCE_INPUT,
  output wire IRQ_OVF,
  output wire IRQ_CH0,
  output wire IRQ_CH1,
  output wire WAKE
);

  function [15:0] merge16;
    input [15:0] old;
    input [31:0] data;
    input [3:0] strb;
    begin
      merge16 = {strb[1] ? data[15:8] : old[15:8], strb[0] ? data[7:0] : old[7:0]};
    end
  endfunction

  // bus slave state
  reg aw_hold;
  reg w_hold;
  reg [7:0] aw_addr;
  reg [31:0] w_data;
  reg [3:0] w_strb;
  reg awready_q;
  reg wready_q;
  reg bvalid_q;
  reg [1:0] bresp_q;
  reg arready_q;
  reg rvalid_q;
  reg [31:0] rdata_q;
  reg [1:0] rresp_q;

  // timer state
  reg sc_flag;
  reg sc_arm;
  reg sc_ie;
  reg sc_halt;
  reg [2:0] sc_ps;
  reg [15:0] cnt;
  reg [15:0] modv;
  reg [5:0] pre;
  reg ext_prev;
  reg act1;
  reg pend1;
  reg irq_ovf_q;
  reg wake_q;
  reg ext_in_q;

  wire [7:0] rd_addr = {ARADDR[7:2], 2'b00};
  wire [7:0] wr_addr = {aw_addr[7:2], 2'b00};
  wire wr_go = aw_hold & w_hold & ~bvalid_q;
  wire rd_go = ARVALID & arready_q;
  wire wr_map = (wr_addr == `TP_OFF_SC) | (wr_addr == `TP_OFF_CNT) | (wr_addr == `TP_OFF_MOD) |
                (wr_addr == `TP_OFF_CH0SC) | (wr_addr == `TP_OFF_CH0CMP) |
                (wr_addr == `TP_OFF_CH1SC) | (wr_addr == `TP_OFF_CH1CMP);
  wire rd_map = (rd_addr == `TP_OFF_SC) | (rd_addr == `TP_OFF_CNT) | (rd_addr == `TP_OFF_MOD) |
                (rd_addr == `TP_OFF_CH0SC) | (rd_addr == `TP_OFF_CH0CMP) |
                (rd_addr == `TP_OFF_CH1SC) | (rd_addr == `TP_OFF_CH1CMP);
  wire wr_en = wr_go & wr_map & ~WAIT_MODE;
  wire rd_en = rd_go & rd_map & ~WAIT_MODE;
  wire protect = BREAK_ACTIVE & ~BREAK_CLEAR_EN;
  wire wr_sc = wr_en & (wr_addr == `TP_OFF_SC) & w_strb[0];
  wire cnt_clr = wr_sc & w_data[`TP_SC_RST];

  // prescaler and counter clock
  wire run = ~sc_halt & ~STOP_MODE & ~BREAK_ACTIVE;
  wire [6:0] pm7 = (7'h01 << sc_ps) - 7'h01;
  wire [5:0] pmask = pm7[5:0];
  wire int_tick = ((pre & pmask) == pmask);
  wire ext_rise = ext_in_q & ~ext_prev;
  wire tick = run & ~cnt_clr & ((sc_ps == `TP_PS_EXT) ? ext_rise : int_tick);
  wire [15:0] next_cnt = (cnt == modv) ? 16'h0000 : cnt + 16'h0001;
  wire ovf_evt = tick & (next_cnt == modv);
  wire linked;
  wire [31:0] cmp_all;
  wire [15:0] flag_ctl_all;
  wire [1:0] pin_all;
  wire [1:0] oe_all;
  wire [1:0] irq_all;
  wire [1:0] ch_in = {CH1_IN, CH0_IN};

  always @(posedge MCLK or posedge RST) begin
    if (RST) begin
      pre <= 6'h00;
      ext_prev <= 1'b0;
      ext_in_q <= 1'b0;
      cnt <= 16'h0000;
    end else begin
      ext_in_q <= EXT_CLK;
      ext_prev <= ext_in_q;
      if (cnt_clr) begin
        pre <= 6'h00;
        cnt <= 16'h0000;
      end else begin
        if (run)
          pre <= pre + 6'h01;
        if (tick)
          cnt <= next_cnt;
      end
    end
  end

  // timer status and control
  always @(posedge MCLK or posedge RST) begin
    if (RST) begin
      sc_flag <= 1'b0;
      sc_arm <= 1'b0;
      sc_ie <= 1'b0;
      sc_halt <= 1'b1;
      sc_ps <= 3'h0;
      modv <= `TP_MOD_RESET;
      irq_ovf_q <= 1'b0;
      wake_q <= 1'b0;
      act1 <= 1'b0;
      pend1 <= 1'b0;
    end else begin
      if (ovf_evt) begin
        sc_flag <= 1'b1;
        sc_arm <= 1'b0;
      end else if (wr_sc & ~w_data[`TP_SC_FLAG] & sc_arm & ~protect) begin
        sc_flag <= 1'b0;
        sc_arm <= 1'b0;
      end else if (rd_en & (rd_addr == `TP_OFF_SC) & sc_flag & ~protect) begin
        sc_arm <= 1'b1;
      end
      if (wr_sc) begin
        sc_ie <= w_data[`TP_SC_IE];
        sc_halt <= w_data[`TP_SC_HALT];
        sc_ps <= w_data[2:0];
      end
      if (wr_en & (wr_addr == `TP_OFF_MOD))
        modv <= merge16(modv, w_data, w_strb);
      irq_ovf_q <= sc_flag & sc_ie;
      wake_q <= (sc_flag & sc_ie) | (|irq_all);
      if (~linked) begin
        act1 <= 1'b0;
        pend1 <= 1'b0;
      end else begin
        if (wr_en & (wr_addr == `TP_OFF_CH0CMP))
          pend1 <= 1'b0;
        else if (wr_en & (wr_addr == `TP_OFF_CH1CMP))
          pend1 <= 1'b1;
        if (ovf_evt)
          act1 <= (wr_en & (wr_addr == `TP_OFF_CH1CMP)) ? 1'b1 :
                  (wr_en & (wr_addr == `TP_OFF_CH0CMP)) ? 1'b0 : pend1;
      end
    end
  end

  // per-channel compare, capture, flag and pin logic
  genvar i;
  generate
    for (i = 0; i < 2; i = i + 1) begin : chan
      reg flag;
      reg arm;
      reg [6:0] ctl;
      reg [15:0] cmp;
      reg pin;
      reg oe;
      reg in_prev;
      reg irq;
      wire [7:0] sc_off = (i == 0) ? `TP_OFF_CH0SC : `TP_OFF_CH1SC;
      wire [7:0] cmp_off = (i == 0) ? `TP_OFF_CH0CMP : `TP_OFF_CH1CMP;
      wire dis = (i == 1) & linked;
      wire mhi = ctl[`TP_CH_MHI];
      wire mlo = ctl[`TP_CH_MLO];
      wire ohi = ctl[`TP_CH_OHI];
      wire olo = ctl[`TP_CH_OLO];
      wire oc = mhi | mlo;
      wire [15:0] eff = ((i == 0) & linked & act1) ? cmp_all[31:16] : cmp;
      wire cmp_evt = tick & oc & ~dis & (next_cnt == eff);
      wire edge_ok = (olo & ch_in[i] & ~in_prev) | (ohi & ~ch_in[i] & in_prev);
      wire cap_evt = ~oc & ~dis & edge_ok & run;
      wire wr_ctl = wr_en & (wr_addr == sc_off) & w_strb[0];
      assign cmp_all[i*16 +: 16] = cmp;
      assign flag_ctl_all[i*8 +: 8] = {flag, ctl};
      assign pin_all[i] = pin;
      assign oe_all[i] = oe;
      assign irq_all[i] = irq;
      always @(posedge MCLK or posedge RST) begin
        if (RST) begin
          flag <= 1'b0;
          arm <= 1'b0;
          ctl <= 7'h00;
          cmp <= 16'h0000;
          pin <= 1'b0;
          oe <= 1'b0;
          in_prev <= 1'b0;
          irq <= 1'b0;
        end else begin
          in_prev <= ch_in[i];
          if (cmp_evt | cap_evt) begin
            flag <= 1'b1;
            arm <= 1'b0;
          end else if (wr_ctl & ~w_data[`TP_CH_FLAG] & arm & ~protect) begin
            flag <= 1'b0;
            arm <= 1'b0;
          end else if (rd_en & (rd_addr == sc_off) & flag & ~protect) begin
            arm <= 1'b1;
          end
          if (wr_ctl)
            ctl <= w_data[6:0];
          if (cap_evt)
            cmp <= cnt;
          else if (wr_en & (wr_addr == cmp_off))
            cmp <= merge16(cmp, w_data, w_strb);
          if (oc & ~dis) begin
            if (ctl[`TP_CH_MAX] & ctl[`TP_CH_TOV])
              pin <= ~olo;
            else if (cmp_evt) begin
              case ({ohi, olo})
                2'b01: pin <= ~pin;
                2'b10: pin <= 1'b0;
                2'b11: pin <= 1'b1;
                default: pin <= pin;
              endcase
            end else if (ovf_evt & ctl[`TP_CH_TOV])
              pin <= ~pin;
          end
          oe <= oc & ~dis & (ohi | olo);
          irq <= flag & ctl[`TP_CH_IE] & ~dis;
        end
      end
    end
  endgenerate

  assign linked = chan[0].ctl[`TP_CH_MHI];

  // axi4-lite slave
  reg [31:0] next_rdata;
  always @* begin
    next_rdata = 32'h0000_0000;
    case (rd_addr)
      `TP_OFF_SC: next_rdata = {24'h000000, sc_flag, sc_ie, sc_halt, 2'b00, sc_ps};
      `TP_OFF_CNT: next_rdata = {16'h0000, cnt};
      `TP_OFF_MOD: next_rdata = {16'h0000, modv};
      `TP_OFF_CH0SC: next_rdata = {24'h000000, flag_ctl_all[7:0]};
      `TP_OFF_CH0CMP: next_rdata = {16'h0000, cmp_all[15:0]};
      `TP_OFF_CH1SC: next_rdata = {24'h000000, flag_ctl_all[15:8]};
      `TP_OFF_CH1CMP: next_rdata = {16'h0000, cmp_all[31:16]};
      default: next_rdata = 32'h0000_0000;
    endcase
  end

  always @(posedge MCLK or posedge RST) begin
    if (RST) begin
      aw_hold <= 1'b0;
      w_hold <= 1'b0;
      aw_addr <= 8'h00;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
      awready_q <= 1'b1;
      wready_q <= 1'b1;
      bvalid_q <= 1'b0;
      bresp_q <= 2'h0;
      arready_q <= 1'b1;
      rvalid_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
      rresp_q <= 2'h0;
    end else begin
      if (AWVALID & awready_q) begin
        aw_hold <= 1'b1;
        aw_addr <= AWADDR;
        awready_q <= 1'b0;
      end
      if (WVALID & wready_q) begin
        w_hold <= 1'b1;
        w_data <= WDATA;
        w_strb <= WSTRB;
        wready_q <= 1'b0;
      end
      if (wr_go) begin
        aw_hold <= 1'b0;
        w_hold <= 1'b0;
        bvalid_q <= 1'b1;
        bresp_q <= (wr_map & ~WAIT_MODE) ? `TP_RESP_OKAY : `TP_RESP_SLVERR;
      end
      if (bvalid_q & BREADY) begin
        bvalid_q <= 1'b0;
        awready_q <= 1'b1;
        wready_q <= 1'b1;
      end
      if (rd_go) begin
        arready_q <= 1'b0;
        rvalid_q <= 1'b1;
        rdata_q <= rd_en ? next_rdata : 32'h0000_0000;
        rresp_q <= rd_en ? `TP_RESP_OKAY : `TP_RESP_SLVERR;
      end
      if (rvalid_q & RREADY) begin
        rvalid_q <= 1'b0;
        arready_q <= 1'b1;
      end
    end
  end

  reg ext_force_q;
  always @(posedge MCLK or posedge RST) begin
    if (RST)
      ext_force_q <= 1'b0;
    else
      ext_force_q <= (sc_ps == `TP_PS_EXT);
  end

  assign AWREADY = awready_q;
  assign WREADY = wready_q;
  assign BVALID = bvalid_q;
  assign BRESP = bresp_q;
  assign ARREADY = arready_q;
  assign RVALID = rvalid_q;
  assign RDATA = rdata_q;
  assign RRESP = rresp_q;
  assign CH0_OUT = pin_all[0];
  assign CH1_OUT = pin_all[1];
  assign CH0_OE = oe_all[0];
  assign CH1_OE = oe_all[1];
  assign IRQ_OVF = irq_ovf_q;
  assign IRQ_CH0 = irq_all[0];
  assign IRQ_CH1 = irq_all[1];
  assign WAKE = wake_q;
  assign EXT_CLK_FORCE_INPUT = ext_force_q;

endmodule

/* File: verilog/tpwm_defines.vh */
// constants of the two-channel pwm timer
`ifndef TPWM_DEFINES_VH
`define TPWM_DEFINES_VH
`define TP_OFF_SC 8'h00
`define TP_OFF_CNT 8'h04
`define TP_OFF_MOD 8'h08
`define TP_OFF_CH0SC 8'h0c
`define TP_OFF_CH0CMP 8'h10
`define TP_OFF_CH1SC 8'h14
`define TP_OFF_CH1CMP 8'h18
`define TP_SC_FLAG 7
`define TP_SC_IE 6
`define TP_SC_HALT 5
`define TP_SC_RST 4
`define TP_CH_FLAG 7
`define TP_CH_IE 6
`define TP_CH_MHI 5
`define TP_CH_MLO 4
`define TP_CH_OHI 3
`define TP_CH_OLO 2
`define TP_CH_TOV 1
`define TP_CH_MAX 0
`define TP_MOD_RESET 16'hffff
`define TP_PS_EXT 3'h7
`define TP_RESP_OKAY 2'h0
`define TP_RESP_SLVERR 2'h2
`endif

/* File: testbench/tpwm_chk.sv */
// port-level assertions for the pwm timer
`timescale 1ns/1ns
module tpwm_chk (
  input wire MCLK,
  input wire RST,
  input wire AWVALID,
  input wire AWREADY,
  input wire WVALID,
  input wire WREADY,
  input wire [1:0] BRESP,
  input wire BVALID,
  input wire BREADY,
  input wire ARVALID,
  input wire ARREADY,
  input wire [31:0] RDATA,
  input wire [1:0] RRESP,
  input wire RVALID,
  input wire RREADY,
  input wire WAIT_MODE,
  input wire STOP_MODE,
  input wire BREAK_ACTIVE,
  input wire CH0_OUT,
  input wire CH1_OUT,
  input wire EXT_CLK_FORCE_INPUT,
  input wire IRQ_OVF,
  input wire IRQ_CH0,
  input wire IRQ_CH1,
  input wire WAKE
);
  default clocking @(posedge MCLK);
  endclocking
  default disable iff (RST);
  AST_B_HOLD:
    assert property (BVALID && !BREADY |=> BVALID && $stable(BRESP)) else $error("write answer dropped");
  AST_R_HOLD:
    assert property (RVALID && !RREADY |=> RVALID && $stable(RDATA) && $stable(RRESP)) else $error("read answer dropped");
  AST_WAIT_RD:
    assert property (ARVALID && ARREADY && WAIT_MODE |=> RVALID && RRESP == 2'h2 && RDATA == 32'h0)
    else $error("read in wait mode not refused");
  AST_WAIT_WR:
    assert property (AWVALID && AWREADY && WVALID && WREADY && WAIT_MODE |=> ##1 BVALID && BRESP == 2'h2)
    else $error("write in wait mode not refused");
  AST_WAKE:
    assert property (IRQ_OVF || IRQ_CH0 || IRQ_CH1 |-> ##[0:1] WAKE) else $error("wake missing");
  AST_STOP:
    assert property (STOP_MODE [*4] |-> $stable(CH0_OUT) && $stable(CH1_OUT)) else $error("pin moved in stop");
  AST_BREAK:
    assert property (BREAK_ACTIVE [*4] |-> $stable(CH0_OUT)) else $error("pin moved in break");
  AST_FORCE:
    assert property ($changed(EXT_CLK_FORCE_INPUT) |-> !AWREADY || !$past(AWREADY)) else $error("force without write");
  AST_IRQ_FALL:
    assert property ($fell(IRQ_OVF) || $fell(IRQ_CH0) || $fell(IRQ_CH1) |-> !AWREADY || !$past(AWREADY))
    else $error("request dropped without write");
endmodule
bind tpwm_top tpwm_chk i_chk (.MCLK, .RST, .AWVALID, .AWREADY, .WVALID, .WREADY, .BRESP, .BVALID, .BREADY,
  .ARVALID, .ARREADY, .RDATA, .RRESP, .RVALID, .RREADY, .WAIT_MODE, .STOP_MODE, .BREAK_ACTIVE, .CH0_OUT,
  .CH1_OUT, .EXT_CLK_FORCE_INPUT, .IRQ_OVF, .IRQ_CH0, .IRQ_CH1, .WAKE);

/* File: testbench/tpwm_pins.sv */
// far-side model: clock source and channel pin loads
`timescale 1ns/1ns
module tpwm_pins (
  input wire mclk,
  input wire run,
  input wire ch0_out,
  input wire ch0_oe,
  input wire ch1_out,
  input wire ch1_oe,
  output reg ext_clk,
  output wire ch0_in,
  output wire ch1_in
);
  reg [1:0] phase = 2'h0;
  reg last0 = 1'h0;
  reg last1 = 1'h0;
  initial ext_clk = 1'h0;
  // one pulse per four cycles, still between bursts
  always @(posedge mclk) begin
    phase <= run ? phase + 2'h1 : 2'h0;
    ext_clk <= run & phase[1];
    last0 <= ch0_oe ? ch0_out : last0;
    last1 <= ch1_oe ? ch1_out : last1;
  end
  // released pins show the inverse of the last driven level
  assign ch0_in = ch0_oe ? ch0_out : ~last0;
  assign ch1_in = ch1_oe ? ch1_out : ~last1;
endmodule

/* File: testbench/timer_pwm_channels_bench.sv */
// self-checking bench for the two-channel pwm timer
`timescale 1ns/1ns
`include "tpwm_defines.vh"
module timer_pwm_channels_bench;
  reg MCLK = 1'h0;
  reg RST = 1'h1;
  reg [7:0] AWADDR = 8'h0;
  reg [7:0] ARADDR = 8'h0;
  reg [31:0] WDATA = 32'h0;
  reg AWVALID = 1'h0, WVALID = 1'h0, BREADY = 1'h0, ARVALID = 1'h0, RREADY = 1'h0, ext_run = 1'h0;
  reg WAIT_MODE = 1'h0, STOP_MODE = 1'h0, BREAK_ACTIVE = 1'h0, BREAK_CLEAR_EN = 1'h0;
  wire AWREADY, WREADY, BVALID, ARREADY, RVALID, EXT_CLK, CH0_IN, CH1_IN, CH0_OUT, CH0_OE, CH1_OUT, CH1_OE;
  wire EXT_CLK_FORCE_INPUT, IRQ_OVF, IRQ_CH0, IRQ_CH1, WAKE;
  wire [1:0] BRESP, RRESP;
  wire [31:0] RDATA;
  integer mismatches = 0, cmp_count = 0, i, m, c, a, h;
  reg [31:0] d, d0;
  tpwm_top i_dut (.MCLK, .RST, .AWADDR, .AWVALID, .AWREADY, .WDATA, .WSTRB(4'hf), .WVALID, .WREADY, .BRESP,
    .BVALID, .BREADY, .ARADDR, .ARVALID, .ARREADY, .RDATA, .RRESP, .RVALID, .RREADY, .WAIT_MODE, .STOP_MODE,
    .BREAK_ACTIVE, .BREAK_CLEAR_EN, .EXT_CLK, .CH0_IN, .CH1_IN, .CH0_OUT, .CH0_OE, .CH1_OUT, .CH1_OE,
    .EXT_CLK_FORCE_INPUT, .IRQ_OVF, .IRQ_CH0, .IRQ_CH1, .WAKE);
  tpwm_pins i_pins (.mclk(MCLK), .run(ext_run), .ch0_out(CH0_OUT), .ch0_oe(CH0_OE), .ch1_out(CH1_OUT),
    .ch1_oe(CH1_OE), .ext_clk(EXT_CLK), .ch0_in(CH0_IN), .ch1_in(CH1_IN));
  initial forever #5 MCLK = ~MCLK;
  task chk(input [31:0] got, input [31:0] exp);
    begin
      cmp_count = cmp_count + 1;
      if (got !== exp) begin
        mismatches = mismatches + 1;
        $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
    end
  endtask
  task final_report;
    begin
      $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
      if (mismatches == 0 && cmp_count > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
    end
  endtask
  task tmo(input integer k);
    if (k >= 60) begin
      mismatches = mismatches + 1;
      final_report;
    end
  endtask
  task wr(input [7:0] ad, input [31:0] v, input [1:0] er);
    integer k;
    begin
      AWADDR <= ad;
      WDATA <= v;
      AWVALID <= 1'h1;
      WVALID <= 1'h1;
      k = 0;
      do begin
        @(posedge MCLK);
        k = k + 1;
        if (AWREADY) AWVALID <= 1'h0;
        if (WREADY) WVALID <= 1'h0;
      end while ((AWVALID & !AWREADY | WVALID & !WREADY) && k < 60);
      repeat ($urandom % 2) @(posedge MCLK);
      BREADY <= 1'h1;
      do begin
        @(posedge MCLK);
        k = k + 1;
      end while (!BVALID && k < 60);
      BREADY <= 1'h0;
      tmo(k);
      chk(BRESP, er);
    end
  endtask
  task rd(input [7:0] ad, input [1:0] er, input [31:0] mk, input [31:0] e);
    integer k;
    begin
      ARADDR <= ad;
      ARVALID <= 1'h1;
      k = 0;
      do begin
        @(posedge MCLK);
        k = k + 1;
      end while (!ARREADY && k < 60);
      ARVALID <= 1'h0;
      repeat ($urandom % 2) @(posedge MCLK);
      RREADY <= 1'h1;
      do begin
        @(posedge MCLK);
        k = k + 1;
      end while (!RVALID && k < 60);
      RREADY <= 1'h0;
      d = RDATA;
      tmo(k);
      chk(RRESP, er);
      chk(d & mk, e);
    end
  endtask
  task meas(input integer w);
    begin
      h = 0;
      repeat (w) begin
        @(posedge MCLK);
        h = h + CH0_OUT;
      end
    end
  endtask
  task wpin(input v);
    integer k;
    begin
      k = 0;
      do begin
        @(posedge MCLK);
        k = k + 1;
      end while (CH0_OUT !== v && k < 60);
      tmo(k);
    end
  endtask
  function integer exp_hi(input integer ps, input integer act);
    exp_hi = (act ? m - c : c + 1) * (8 << ps);
  endfunction
  task setup(input integer ps, input integer act);
    begin
      wr(`TP_OFF_SC, 32'h30, 2'h0);
      wr(`TP_OFF_MOD, m, 2'h0);
      wr(`TP_OFF_CH0CMP, c, 2'h0);
      wr(`TP_OFF_CH0SC, 32'h5a | (act << 2), 2'h0);
      wr(`TP_OFF_SC, 32'h40 | ps, 2'h0);
      repeat (3 * (m + 1) << ps) @(posedge MCLK);
    end
  endtask
  initial begin
    d = $urandom(37424);
    repeat (3) @(posedge MCLK);
    RST <= 1'h0;
    @(posedge MCLK);
    rd(`TP_OFF_SC, 2'h0, 32'hff, 32'h20);
    rd(`TP_OFF_MOD, 2'h0, 32'hffffffff, 32'hffff);
    rd(8'h1c, 2'h2, 32'hffffffff, 32'h0);
    for (i = 0; i < 7; i = i + 1) begin
      m = 3 + $urandom % 6;
      c = 1 + $urandom % (m - 1);
      a = $urandom % 2;
      setup(i, a);
      meas((m + 1) * (8 << i));
      chk(h, exp_hi(i, a));
    end
    chk({IRQ_OVF, IRQ_CH0, WAKE}, 3'h7);
    WAIT_MODE <= 1'h1;
    rd(`TP_OFF_SC, 2'h2, 32'hffffffff, 32'h0);
    wr(`TP_OFF_SC, 32'h20, 2'h2);
    chk(WAKE, 1'h1);
    WAIT_MODE <= 1'h0;
    rd(`TP_OFF_SC, 2'h0, 32'h27, 32'h06);
    m = 3;
    c = 1;
    setup(0, 0);
    // longer width written inside the pulse, shorter one after it
    wpin(1'h1);
    c = 2;
    wr(`TP_OFF_CH0CMP, c, 2'h0);
    repeat (8) @(posedge MCLK);
    meas(32);
    chk(h, exp_hi(0, 0));
    wpin(1'h0);
    c = 1;
    wr(`TP_OFF_CH0CMP, c, 2'h0);
    repeat (8) @(posedge MCLK);
    meas(32);
    chk(h, exp_hi(0, 0));
    wr(`TP_OFF_CH1SC, 32'h5a, 2'h0);
    repeat (8) @(posedge MCLK);
    chk({CH0_OE, CH1_OE, IRQ_CH1}, 3'h7);
    wr(`TP_OFF_CH0SC, 32'h3a, 2'h0);
    repeat (8) @(posedge MCLK);
    chk({CH0_OE, CH1_OE, IRQ_CH1}, 3'h4);
    meas(32);
    chk(h, exp_hi(0, 0));
    c = 2;
    wr(`TP_OFF_CH1CMP, c, 2'h0);
    repeat (8) @(posedge MCLK);
    meas(32);
    chk(h, exp_hi(0, 0));
    c = 1;
    wr(`TP_OFF_CH0CMP, c, 2'h0);
    repeat (8) @(posedge MCLK);
    meas(32);
    chk(h, exp_hi(0, 0));
    wr(`TP_OFF_CH0SC, 32'h18, 2'h0);
    repeat (8) @(posedge MCLK);
    meas(32);
    chk(h, 0);
    wr(`TP_OFF_CH0SC, 32'h1b, 2'h0);
    repeat (8) @(posedge MCLK);
    meas(32);
    chk(h, 32);
    for (i = 0; i < 2; i = i + 1) begin
      STOP_MODE <= (i == 0);
      BREAK_ACTIVE <= (i == 1);
      rd(`TP_OFF_CNT, 2'h0, 32'hfffffffc, 32'h0);
      d0 = d;
      repeat (20) @(posedge MCLK);
      rd(`TP_OFF_CNT, 2'h0, 32'hffffffff, d0);
    end
    BREAK_ACTIVE <= 1'h0;
    wr(`TP_OFF_SC, 32'h60, 2'h0);
    rd(`TP_OFF_SC, 2'h0, 32'h80, 32'h80);
    BREAK_ACTIVE <= 1'h1;
    BREAK_CLEAR_EN <= 1'h1;
    rd(`TP_OFF_CH0SC, 2'h0, 32'h80, 32'h80);
    wr(`TP_OFF_CH0SC, 32'h1b, 2'h0);
    rd(`TP_OFF_CH0SC, 2'h0, 32'h80, 32'h0);
    BREAK_CLEAR_EN <= 1'h0;
    BREAK_ACTIVE <= 1'h1;
    wr(`TP_OFF_SC, 32'h60, 2'h0);
    rd(`TP_OFF_SC, 2'h0, 32'h80, 32'h80);
    BREAK_ACTIVE <= 1'h0;
    wr(`TP_OFF_SC, 32'h60, 2'h0);
    rd(`TP_OFF_SC, 2'h0, 32'h80, 32'h0);
    chk(IRQ_OVF, 1'h0);
    wr(`TP_OFF_SC, 32'h30, 2'h0);
    wr(`TP_OFF_MOD, 32'hffff, 2'h0);
    wr(`TP_OFF_SC, 32'h07, 2'h0);
    @(posedge MCLK);
    chk(EXT_CLK_FORCE_INPUT, 1'h1);
    ext_run <= 1'h1;
    repeat (40) @(posedge MCLK);
    ext_run <= 1'h0;
    repeat (6) @(posedge MCLK);
    rd(`TP_OFF_CNT, 2'h0, 32'hffffffff, 32'ha);
    wr(`TP_OFF_SC, 32'h20, 2'h0);
    @(posedge MCLK);
    chk(EXT_CLK_FORCE_INPUT, 1'h0);
    final_report;
  end
endmodule
